// [design/sbc_sfr_bank.sv]
// special function register bank with upper code map and bank select
// Functional notes
// (RQ1) byte access to every register; bit access only at multiples of 8
// (RQ2) isp flag reads 1 while mode pins equal 3; writes ignored
// (RQ3) map bit 1 sends fetches 0xfc00-0xffff to boot rom, else to nvm
// (RQ4) bank select bit 0: 0 picks bank zero (reset), 1 bank one
// (RQ5) every register loads its listed initial value on reset
// (RQ6) 8-bit read/write operand register, reset to zero
// (RQ7) bank 0 maps lower 64KB; bank 1 lower 32KB plus upper 32KB
// (RQ8) common 0x00000-0x07fff, bank0 0x08000-, bank1 0x10000-0x17fff
// (RQ9) reserved bits of map control and bank select ignore writes, read 0
`timescale 1ns/1ns
`default_nettype none

module sbc_sfr_bank (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr_en,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic [7:0] bit_addr,
  input wire logic bit_wr_en,
  input wire logic bit_wdata,
  output logic bit_rdata,
  input wire logic [1:0] mode_select_pins,
  input wire logic [15:0] fetch_addr,
  output logic fetch_boot_rom,
  output logic [16:0] fetch_phys_addr,
  output logic isp_mode_flag,
  output logic boot_rom_map_enable,
  output logic code_bank_select,
  output logic [7:0] main_operand_register
);

  typedef struct packed {
    logic [sbc_pkg::SBC_NREG-1:0][7:0] sfr;
    logic [2:0][1:0] ms;
    logic isp;
    logic [7:0] rdata;
    logic bit_rdata;
    logic boot;
    logic [16:0] phys;
  } sbc_state_s;

  sbc_state_s st_q;
  sbc_state_s st_d;
  logic [sbc_pkg::SBC_NREG-1:0][7:0] view;
  logic [6:0] byte_hit;
  logic [6:0] bit_hit;

  // lookup of an offset: {hit, index}
  function automatic logic [6:0] sbc_find(input logic [7:0] a);
    logic [6:0] r;
    r = 7'h00;
    for (int i = 0; i < sbc_pkg::SBC_NREG; i++) begin
      if (a == sbc_pkg::SBC_OFFS[i]) begin
        r = {1'b1, 6'(i)};
      end
    end
    return r;
  endfunction

  // writable bits of a register; reserved bits stay zero
  function automatic logic [7:0] sbc_wmask(input logic [5:0] idx);
    logic [7:0] m;
    m = sbc_pkg::SBC_FULL_WMASK;
    if (idx == sbc_pkg::SBC_I_MAPCTL) begin
      m = sbc_pkg::SBC_MAPCTL_WMASK; // RQ2
    end else if (idx == sbc_pkg::SBC_I_BANKSEL) begin
      m = sbc_pkg::SBC_BANKSEL_WMASK; // RQ9
    end
    return m;
  endfunction

  function automatic sbc_state_s sbc_reset_state();
    sbc_state_s s;
    s = '0;
    for (int i = 0; i < sbc_pkg::SBC_NREG; i++) begin
      s.sfr[i] = sbc_pkg::SBC_RSTV[i];
    end
    return s;
  endfunction

  assign byte_hit = sbc_find(sfr_addr);
  // bit addresses from 0x80 up name bit [2:0] of the aligned byte
  assign bit_hit = sbc_find({bit_addr[7:3], sbc_pkg::SBC_BIT_ALIGN});

  always_comb begin
    logic [5:0] bi;
    logic [5:0] xi;
    logic [7:0] m;
    bi = byte_hit[5:0];
    xi = bit_hit[5:0];
    m = 8'h00;
    st_d = st_q;
    view = st_q.sfr;
    view[sbc_pkg::SBC_I_MAPCTL][sbc_pkg::SBC_ISP_BIT] = st_q.isp;

    // three-stage pin synchroniser; stage two and three must agree
    st_d.ms[0] = mode_select_pins;
    st_d.ms[1] = st_q.ms[0];
    st_d.ms[2] = st_q.ms[1];
    if (st_q.ms[1] == st_q.ms[2]) begin
      st_d.isp = (st_q.ms[2] == sbc_pkg::SBC_ISP_CODE); // RQ2
    end

    // byte write; the bit port may then override one bit of it
    if (sfr_wr_en && byte_hit[6]) begin
      m = sbc_wmask(bi);
      st_d.sfr[bi] = sfr_wdata & m; // RQ1
    end
    // bits below 0x80 belong to ram, not to this bank
    if (bit_wr_en && bit_addr[7] && bit_hit[6]) begin
      m = sbc_wmask(xi);
      if (m[bit_addr[2:0]]) begin
        st_d.sfr[xi][bit_addr[2:0]] = bit_wdata; // RQ1
      end
    end

    // reads are registered: data shows one edge after the address
    if (byte_hit[6]) begin
      st_d.rdata = view[bi];
    end else begin
      st_d.rdata = 8'h00;
    end
    if (bit_addr[7] && bit_hit[6]) begin
      st_d.bit_rdata = view[xi][bit_addr[2:0]];
    end else begin
      st_d.bit_rdata = 1'b0;
    end

    // code fetch decode uses the settings in force before this edge
    st_d.boot = st_q.sfr[sbc_pkg::SBC_I_MAPCTL][sbc_pkg::SBC_ROM_BIT]
      && (fetch_addr >= sbc_pkg::SBC_BOOT_BASE); // RQ3
    if (st_d.boot) begin
      // rom is only 1KB deep, so only the low ten bits matter
      st_d.phys = {7'h00, fetch_addr[9:0]};
    end else if (fetch_addr[15]
      && st_q.sfr[sbc_pkg::SBC_I_BANKSEL][sbc_pkg::SBC_BANK_BIT]) begin
      st_d.phys = {sbc_pkg::SBC_BANK1_TOP, fetch_addr[14:0]}; // RQ7 RQ8
    end else begin
      st_d.phys = {1'b0, fetch_addr}; // RQ7 RQ8
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= sbc_reset_state(); // RQ5
    end else begin
      st_q <= st_d;
    end
  end

  assign sfr_rdata = st_q.rdata;
  assign bit_rdata = st_q.bit_rdata;
  assign fetch_boot_rom = st_q.boot;
  assign fetch_phys_addr = st_q.phys;
  assign isp_mode_flag = st_q.isp;
  assign boot_rom_map_enable =
    st_q.sfr[sbc_pkg::SBC_I_MAPCTL][sbc_pkg::SBC_ROM_BIT];
  assign code_bank_select =
    st_q.sfr[sbc_pkg::SBC_I_BANKSEL][sbc_pkg::SBC_BANK_BIT]; // RQ4
  assign main_operand_register = st_q.sfr[sbc_pkg::SBC_I_OPER]; // RQ6

  // checks

  logic up_q;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      up_q <= 1'b0;
    end else begin
      up_q <= 1'b1;
    end
  end

  logic oper_wr;
  logic mapctl_wr;
  logic oper_bit_wr;
  assign oper_wr = sfr_wr_en
    && (sfr_addr == sbc_pkg::SBC_OFFS[sbc_pkg::SBC_I_OPER]);
  assign mapctl_wr = sfr_wr_en
    && (sfr_addr == sbc_pkg::SBC_OFFS[sbc_pkg::SBC_I_MAPCTL]);
  assign oper_bit_wr = bit_wr_en && bit_addr[7]
    && ({bit_addr[7:3], 3'h0} == sbc_pkg::SBC_OFFS[sbc_pkg::SBC_I_OPER]);

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  a_reset_values: assert property ( // RQ5
    !up_q |-> st_q.sfr[sbc_pkg::SBC_I_STACK] == 8'h07
      && st_q.sfr[sbc_pkg::SBC_I_WDOG] == 8'h0b
      && st_q.sfr[sbc_pkg::SBC_I_PORT3] == 8'h3f
      && st_q.sfr[sbc_pkg::SBC_I_P1OE] == 8'h7f
      && boot_rom_map_enable && !code_bank_select
      && main_operand_register == 8'h00)
    else $error("register not at its reset value");

  a_oper_write: assert property ( // RQ6
    oper_wr && !oper_bit_wr |=>
      main_operand_register == $past(sfr_wdata))
    else $error("operand register missed a byte write");

  a_bit_write_one: assert property ( // RQ1
    oper_bit_wr && !oper_wr |=>
      ((main_operand_register ^ $past(main_operand_register))
        & ~(8'h01 << $past(bit_addr[2:0]))) == 8'h00
      && main_operand_register[$past(bit_addr[2:0])]
        == $past(bit_wdata))
    else $error("bit write touched the wrong bit");

  a_isp_follow: assert property ( // RQ2
    mode_select_pins == sbc_pkg::SBC_ISP_CODE [*4] |=> isp_mode_flag)
    else $error("isp flag not set after pins settle at three");

  a_isp_readonly: assert property ( // RQ2
    mapctl_wr && $stable(st_q.ms) && st_q.ms[1] == st_q.ms[2]
      && (st_q.ms[2] == sbc_pkg::SBC_ISP_CODE) == isp_mode_flag
      |=> $stable(isp_mode_flag))
    else $error("software write moved the isp flag");

  a_rom_decode: assert property ( // RQ3
    boot_rom_map_enable && fetch_addr >= 16'hfc00
      |=> fetch_boot_rom && fetch_phys_addr[9:0] == $past(fetch_addr[9:0]))
    else $error("upper 1KB not sent to boot rom");

  a_nvm_decode: assert property ( // RQ3
    !boot_rom_map_enable |=> !fetch_boot_rom)
    else $error("boot rom chosen while map bit is clear");

  a_bank_one: assert property ( // RQ7
    code_bank_select && fetch_addr[15] && !boot_rom_map_enable
      |=> fetch_phys_addr == 17'h10000 + 17'($past(fetch_addr[14:0])))
    else $error("bank one fetch not in the upper array");

  a_common_area: assert property ( // RQ8
    !fetch_addr[15] |=> fetch_phys_addr == {1'b0, $past(fetch_addr)})
    else $error("common area fetch relocated");

  a_bank_zero: assert property ( // RQ4
    !code_bank_select && fetch_addr[15] && !boot_rom_map_enable
      |=> fetch_phys_addr == {1'b0, $past(fetch_addr)})
    else $error("bank zero fetch relocated");

  a_reserved_zero: assert property ( // RQ9
    sfr_addr == sbc_pkg::SBC_OFFS[sbc_pkg::SBC_I_MAPCTL]
      |=> (sfr_rdata & 8'hf9) == 8'h00)
    else $error("map control reserved bit reads one");

  a_bank_reserved: assert property ( // RQ9
    st_q.sfr[sbc_pkg::SBC_I_BANKSEL][7:1] == 7'h00
      && st_q.sfr[sbc_pkg::SBC_I_MAPCTL][7:2] == 6'h00
      && !st_q.sfr[sbc_pkg::SBC_I_MAPCTL][0])
    else $error("reserved bit held a written value");

  c_bank_one_fetch: cover property (
    code_bank_select && fetch_addr[15] ##1 fetch_phys_addr[16]);
  c_rom_unmapped: cover property (
    mapctl_wr && sfr_wdata == 8'h00 ##1 !boot_rom_map_enable);
  c_isp_entry: cover property ($rose(isp_mode_flag));
  c_bit_write: cover property (oper_bit_wr);
  c_pair_write: cover property (oper_wr && oper_bit_wr);

  // helper decodes for the checks below; the offset search is written
  // again here so that a fault in the datapath lookup is not mirrored
  logic acc_byte_rd;
  logic stack_wr;
  logic bank_wr;
  logic low_bit_wr;
  logic mapctl_bit_wr;
  logic unmapped_rd;
  assign acc_byte_rd =
    (sfr_addr == sbc_pkg::SBC_OFFS[sbc_pkg::SBC_I_OPER]);
  assign stack_wr = sfr_wr_en
    && (sfr_addr == sbc_pkg::SBC_OFFS[sbc_pkg::SBC_I_STACK]);
  assign bank_wr = sfr_wr_en
    && (sfr_addr == sbc_pkg::SBC_OFFS[sbc_pkg::SBC_I_BANKSEL]);
  assign low_bit_wr = bit_wr_en && !bit_addr[7];
  assign mapctl_bit_wr = bit_wr_en && bit_addr[7]
    && ({bit_addr[7:3], 3'h0} == sbc_pkg::SBC_OFFS[sbc_pkg::SBC_I_MAPCTL]);

  always_comb begin
    unmapped_rd = 1'b1;
    for (int i = 0; i < sbc_pkg::SBC_NREG; i++) begin
      if (sfr_addr == sbc_pkg::SBC_OFFS[i]) begin
        unmapped_rd = 1'b0;
      end
    end
  end

  // holes in the map must read as zero, never as a stale byte
  a_unmapped_zero: assert property ( // RQ1
    unmapped_rd |=> sfr_rdata == 8'h00)
    else $error("unmapped address read non-zero");

  a_read_follow: assert property ( // RQ6
    acc_byte_rd |=> sfr_rdata == $past(main_operand_register))
    else $error("operand read did not return the register");

  a_stack_write: assert property ( // RQ1
    stack_wr |=> st_q.sfr[sbc_pkg::SBC_I_STACK] == $past(sfr_wdata))
    else $error("stack pointer missed a byte write");

  // bit addresses below the bank belong to ram and must not leak in
  a_low_bit_ignored: assert property ( // RQ1
    low_bit_wr && !sfr_wr_en |=> $stable(main_operand_register))
    else $error("low bit address changed the operand register");

  a_low_bit_zero: assert property ( // RQ1
    !bit_addr[7] |=> !bit_rdata)
    else $error("low bit address read one");

  // same-cycle byte and bit writes: the single bit wins
  a_pair_override: assert property ( // RQ1
    oper_wr && oper_bit_wr |=>
      main_operand_register[$past(bit_addr[2:0])] == $past(bit_wdata))
    else $error("bit write lost against a byte write");

  a_bank_write: assert property ( // RQ4
    bank_wr |=> code_bank_select == $past(sfr_wdata[0]))
    else $error("bank select missed a byte write");

  a_map_write: assert property ( // RQ3
    mapctl_wr && !mapctl_bit_wr
      |=> boot_rom_map_enable == $past(sfr_wdata[1]))
    else $error("map bit missed a byte write");

  // pins that wander without settling are not checked: the flag may lag
  a_isp_clear: assert property ( // RQ2
    (mode_select_pins != sbc_pkg::SBC_ISP_CODE
      && $stable(mode_select_pins)) [*4] |=> !isp_mode_flag)
    else $error("isp flag stayed set with pins away from three");

  a_isp_read: assert property ( // RQ2
    isp_mode_flag && sfr_addr == sbc_pkg::SBC_OFFS[sbc_pkg::SBC_I_MAPCTL]
      |=> sfr_rdata[2])
    else $error("isp flag not visible in map control read");

  // the boot rom is 1KB deep, so no high offset bit may be driven
  a_rom_offset: assert property ( // RQ3
    fetch_boot_rom |-> fetch_phys_addr[16:10] == 7'h00)
    else $error("boot rom offset beyond its depth");

endmodule

`default_nettype wire

// [pkg/sbc_pkg.sv]
// constants for the special function register bank and code map
package sbc_pkg;
  localparam int SBC_NREG = 39;
  // byte offsets of every register, index order
  localparam logic [7:0] SBC_OFFS [SBC_NREG] = '{
    8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h87, 8'h88,
    8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'h90, 8'h91, 8'ha1,
    8'ha2, 8'ha8, 8'ha9, 8'haa, 8'hab, 8'hac, 8'had, 8'hb0,
    8'hb1, 8'hb2, 8'hb4, 8'hb8, 8'hb9, 8'hba, 8'hbc, 8'hc0,
    8'hd0, 8'hd2, 8'hd8, 8'he0, 8'he8, 8'hf0, 8'hf8
  };
  // reset values, same order; map control holds the rom map bit set
  localparam logic [7:0] SBC_RSTV [SBC_NREG] = '{
    8'hff, 8'h07, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h3f,
    8'hff, 8'h7f, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02,
    8'h00, 8'h0b, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00
  };
  // indices of registers the logic looks at
  localparam logic [5:0] SBC_I_STACK = 6'h01;
  localparam logic [5:0] SBC_I_BANKSEL = 6'h0f;
  localparam logic [5:0] SBC_I_PORT3 = 6'h17;
  localparam logic [5:0] SBC_I_P1OE = 6'h19;
  localparam logic [5:0] SBC_I_MAPCTL = 6'h1f;
  localparam logic [5:0] SBC_I_WDOG = 6'h21;
  localparam logic [5:0] SBC_I_OPER = 6'h23;
  // field positions and writable masks
  localparam int SBC_ISP_BIT = 2;
  localparam int SBC_ROM_BIT = 1;
  localparam int SBC_BANK_BIT = 0;
  localparam logic [7:0] SBC_MAPCTL_WMASK = 8'h02;
  localparam logic [7:0] SBC_BANKSEL_WMASK = 8'h01;
  localparam logic [7:0] SBC_FULL_WMASK = 8'hff;
  // bit-addressable registers sit at offsets with low three bits zero
  localparam logic [2:0] SBC_BIT_ALIGN = 3'h0;
  localparam logic [1:0] SBC_ISP_CODE = 2'h3;
  // code space
  localparam logic [15:0] SBC_BOOT_BASE = 16'hfc00;
  localparam logic [1:0] SBC_BANK1_TOP = 2'h2;
endpackage

// [tb/sbc_pin_model.sv]
// model of the mode select pins as the board straps them
`timescale 1ns/1ns
`default_nettype none

module sbc_pin_model (
  input wire logic ref_clk,
  input wire logic isp_req,
  output logic [1:0] mode_select_pins
);
  // pins change on a clock edge, well apart from any glitch window
  always_ff @(posedge ref_clk) begin
    mode_select_pins <= isp_req ? 2'h3 : 2'h1;
  end
endmodule

`default_nettype wire

// [tb/sbc_sfr_bank_tb_top.sv]
// self-checking bench for the register bank and code map
`timescale 1ns/1ns
`default_nettype none

`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
  $display("wrong value at %0t: got %h exp %h", $time, a, b); end end

module sbc_sfr_bank_tb_top;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, bit_addr = 8'h00;
  logic sfr_wr_en = 1'b0, bit_wr_en = 1'b0, bit_wdata = 1'b0;
  logic isp_req = 1'b0;
  logic [15:0] fetch_addr = 16'h0000;
  logic [1:0] mode_select_pins;
  logic [7:0] sfr_rdata, main_operand_register;
  logic bit_rdata, fetch_boot_rom, isp_mode_flag;
  logic boot_rom_map_enable, code_bank_select;
  logic [16:0] fetch_phys_addr;
  int failures = 0, n_checks = 0, cycles = 0;
  logic [7:0] msk;

  always #5 ref_clk = ~ref_clk;

  sbc_pin_model sbc_pin_model_inst (.ref_clk(ref_clk), .isp_req(isp_req),
    .mode_select_pins(mode_select_pins));

  sbc_sfr_bank sbc_sfr_bank_inst (.ref_clk(ref_clk), .reset_n(reset_n),
    .sfr_addr(sfr_addr), .sfr_wr_en(sfr_wr_en), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .bit_addr(bit_addr), .bit_wr_en(bit_wr_en),
    .bit_wdata(bit_wdata), .bit_rdata(bit_rdata),
    .mode_select_pins(mode_select_pins), .fetch_addr(fetch_addr),
    .fetch_boot_rom(fetch_boot_rom), .fetch_phys_addr(fetch_phys_addr),
    .isp_mode_flag(isp_mode_flag),
    .boot_rom_map_enable(boot_rom_map_enable),
    .code_bank_select(code_bank_select),
    .main_operand_register(main_operand_register));

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // write is taken at the edge after the request is launched
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr_en <= 1'b1;
    @(posedge ref_clk);
    sfr_wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    sfr_addr <= a;
    @(posedge ref_clk);
    #1 `CHK(sfr_rdata, e)
  endtask

  task automatic bwr(input logic [7:0] a, input logic v);
    @(posedge ref_clk);
    bit_addr <= a;
    bit_wdata <= v;
    bit_wr_en <= 1'b1;
    @(posedge ref_clk);
    bit_wr_en <= 1'b0;
  endtask

  task automatic brd(input logic [7:0] a, input logic e);
    @(posedge ref_clk);
    bit_addr <= a;
    @(posedge ref_clk);
    #1 `CHK(bit_rdata, e)
  endtask

  task automatic ftc(input logic [15:0] a, input logic b,
                     input logic [16:0] p);
    @(posedge ref_clk);
    fetch_addr <= a;
    @(posedge ref_clk);
    #1 `CHK(fetch_boot_rom, b)
    `CHK(fetch_phys_addr, p)
  endtask

  // cut a hang short well beyond the roughly 450 cycles the run needs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      conclude();
    end
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < sbc_pkg::SBC_NREG; i++) begin
      rd(sbc_pkg::SBC_OFFS[i], sbc_pkg::SBC_RSTV[i]);
    end
    `CHK(boot_rom_map_enable, 1'b1)
    `CHK(code_bank_select, 1'b0)
    rd(8'h86, 8'h00);
    $display("reset values done");
    // two inverse patterns so every writable bit goes both ways
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < sbc_pkg::SBC_NREG; i++) begin
        msk = sbc_pkg::SBC_FULL_WMASK;
        if (i == sbc_pkg::SBC_I_MAPCTL) msk = sbc_pkg::SBC_MAPCTL_WMASK;
        if (i == sbc_pkg::SBC_I_BANKSEL) msk = sbc_pkg::SBC_BANKSEL_WMASK;
        wr(sbc_pkg::SBC_OFFS[i], p ? 8'ha5 : 8'h5a);
        rd(sbc_pkg::SBC_OFFS[i], (p ? 8'ha5 : 8'h5a) & msk);
      end
    end
    `CHK(main_operand_register, 8'ha5)
    `CHK(code_bank_select, 1'b1)
    `CHK(boot_rom_map_enable, 1'b0)
    $display("byte access done");
    ftc(16'h9000, 1'b0, 17'h11000);
    ftc(16'hfc10, 1'b0, 17'h17c10);
    wr(8'hc0, 8'h02);
    ftc(16'hfc10, 1'b1, 17'h00010);
    wr(8'ha1, 8'h00);
    ftc(16'h9000, 1'b0, 17'h09000);
    ftc(16'h1234, 1'b0, 17'h01234);
    $display("fetch decode done");
    bwr(8'he3, 1'b1);
    #1 `CHK(main_operand_register, 8'had)
    brd(8'he3, 1'b1);
    bwr(8'h03, 1'b0);
    brd(8'he3, 1'b1);
    brd(8'hc9, 1'b0);
    bwr(8'hc0, 1'b1);
    brd(8'hc0, 1'b0);
    bwr(8'hc2, 1'b1);
    brd(8'hc2, 1'b0);
    $display("bit access done");
    @(posedge ref_clk);
    isp_req <= 1'b1;
    repeat (7) @(posedge ref_clk);
    #1 `CHK(isp_mode_flag, 1'b1)
    wr(8'hc0, 8'h00);
    rd(8'hc0, 8'h04);
    @(posedge ref_clk);
    isp_req <= 1'b0;
    repeat (7) @(posedge ref_clk);
    #1 `CHK(isp_mode_flag, 1'b0)
    $display("mode pins done");
    conclude();
  end
endmodule

`default_nettype wire
